//--- ioc_pkg.sv
// package for the io cycle control logic: widths, device table, timing counts
package ioc_pkg;
  localparam int ADDR_W = 32;                            // processor address width
  localparam int DEV_N = 4;                              // number of slave device selects
  localparam int CNT_W = 8;                              // wait / recovery counter width
  localparam int CLK_PERIOD_PS = 5000;                   // 200 MHz system clock
  // device decode: io region is one contiguous block, devices by two address bits
  localparam logic [ADDR_W-1:0] IO_BASE = 32'h0700_0000;
  localparam logic [ADDR_W-1:0] IO_MASK = 32'hFF00_0000;
  localparam int DEV_SEL_LSB = 19;                       // device index field position
  // command setup after chip select, in clocks
  localparam logic [CNT_W-1:0] CS_SETUP_CLKS = 8'h02;
  // minimum command active time per device, ns (within the 100..400 ns span)
  localparam int CMD_MIN_NS_0 = 100;
  localparam int CMD_MIN_NS_1 = 200;
  localparam int CMD_MIN_NS_2 = 300;
  localparam int CMD_MIN_NS_3 = 400;
  // clocks of command active, least time rounds up
  localparam int CMD_CLKS_0 = (CMD_MIN_NS_0 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CMD_CLKS_1 = (CMD_MIN_NS_1 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CMD_CLKS_2 = (CMD_MIN_NS_2 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CMD_CLKS_3 = (CMD_MIN_NS_3 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // slowest device data float / recovery time
  localparam int RECOVERY_NS = 120;
  localparam int RECOVERY_CLKS = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write data drive delay after a read with long float delay
  localparam int WDATA_DELAY_CLKS = 3;
  // ready delay after write command rises, for write data hold
  localparam int WR_HOLD_CLKS = 1;
endpackage

//--- ioc_down_counter.sv
// loadable down counter used for wait states and recovery
`timescale 1ns/1ps
`default_nettype none
module ioc_down_counter #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  output var  logic         busy_out,
  output var  logic         zero_out
);
  logic [W-1:0] count_q;

  // load wins over counting; stops at zero
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else if (load_in) begin
      count_q <= value_in;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign busy_out = (count_q != '0);
  assign zero_out = (count_q == '0);
endmodule
`default_nettype wire

//--- ioc_io_cycle_control.sv
// io cycle control: decodes processor cycles and drives slow slave commands
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - io versus memory is told only by address decode into two region selects
// - cacheable_n held inactive (high) whenever the io region is selected
// - address and data buffers toward slaves enabled during io cycles
// - address latch enable comes from the latched cycle strobe
// - latched strobe plus io select starts read or write per write_not_read
// - no io cycle starts while dram_pending is high
// - wait states chosen per selected device from the device selects
// - wait states added by holding the active-low ready back
// - ready output floats unless this block terminates the cycle
// - unlatched device selects sampled only with the latched strobe
// - chip select latch cleared (all high) the clock after ready returned
// - command asserted at least two clocks after chip select for setup
// - command stays active for the device's minimum active time
// - chip selects and addresses held in latches past command end
// - write data drive postponed several clocks after a read
// - write ready delayed after rising edge of write command
// - recovery hold between back-to-back accesses blocks any command
// - after a read, recovery hold lasts until old data has floated
// - read command waits for recovery hold to clear
// - write command two clocks after chip select, later while recovery hold or write data delay runs
module ioc_io_cycle_control
  import ioc_pkg::*;
(
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  // processor local bus
  input  wire logic [ioc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                     bus_cycle_strobe_n_in,
  input  wire logic                     latched_cycle_strobe_n_in,
  input  wire logic                     write_not_read_in,
  input  wire logic                     dram_pending_in,
  output logic                          cacheable_n_out,
  output logic                          ready_n_out,
  output logic                          ready_n_oe_n_out,
  output logic                          addr_latch_en_out,
  // slave side
  output logic [ioc_pkg::ADDR_W-1:0]    io_addr_out,
  output logic [ioc_pkg::DEV_N-1:0]     dev_cs_n_out,
  output logic                          io_read_cmd_n_out,
  output logic                          io_write_cmd_n_out,
  output logic                          addr_buf_en_n_out,
  output logic                          data_buf_en_n_out,
  output logic                          data_dir_write_out,
  output logic                          recovery_hold_out,
  output logic                          io_region_select_out,
  output logic                          memory_region_select_out
);
  import ioc_pkg::*;

  typedef enum logic [2:0] {
    IOC_IDLE, IOC_SETUP, IOC_CMD, IOC_WHOLD, IOC_READY
  } ioc_state_t;

  // two-flop synchronisers for pin inputs; only the second flop feeds logic
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic              ads_s1_q, ads_s2_q, latched_cycle_strobe_n_s1_q, latched_cycle_strobe_n_s2_q;
  logic              wnr_s1_q, wnr_s2_q, busy_s1_q, busy_s2_q;

  // address pins: same depth as the strobe, so the word is settled when it is taken
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_s1_q <= '0;
      addr_s2_q <= '0;
    end else begin
      addr_s1_q <= addr_in;
      addr_s2_q <= addr_s1_q;
    end
  end

  // cycle strobe, idle high after reset so no false cycle follows it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ads_s1_q <= 1'b1;
      ads_s2_q <= 1'b1;
    end else begin
      ads_s1_q <= bus_cycle_strobe_n_in;
      ads_s2_q <= ads_s1_q;
    end
  end

  // latched strobe, idle high after reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latched_cycle_strobe_n_s1_q <= 1'b1;
      latched_cycle_strobe_n_s2_q <= 1'b1;
    end else begin
      latched_cycle_strobe_n_s1_q <= latched_cycle_strobe_n_in;
      latched_cycle_strobe_n_s2_q <= latched_cycle_strobe_n_s1_q;
    end
  end

  // write-not-read line
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wnr_s1_q <= 1'b0;
      wnr_s2_q <= 1'b0;
    end else begin
      wnr_s1_q <= write_not_read_in;
      wnr_s2_q <= wnr_s1_q;
    end
  end

  // dram pending indication
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= dram_pending_in;
      busy_s2_q <= busy_s1_q;
    end
  end

  // address decode: only the address tells io from memory
  logic              io_sel, mem_sel, latched_cycle_strobe_n_act;
  logic [1:0]        dev_idx;
  assign io_sel   = ((addr_s2_q & IO_MASK) == IO_BASE);
  assign mem_sel  = !io_sel;
  assign latched_cycle_strobe_n_act = !latched_cycle_strobe_n_s2_q;
  assign dev_idx  = addr_s2_q[DEV_SEL_LSB +: 2];

  // per-device command clocks, worst case would be CMD_CLKS_3
  function automatic logic [CNT_W-1:0] dev_wait(input logic [1:0] idx);
    logic [CNT_W-1:0] w;
    w = CNT_W'(CMD_CLKS_3);
    case (idx)
      2'h0: w = CNT_W'(CMD_CLKS_0);
      2'h1: w = CNT_W'(CMD_CLKS_1);
      2'h2: w = CNT_W'(CMD_CLKS_2);
      default: w = CNT_W'(CMD_CLKS_3);
    endcase
    return w;
  endfunction

  ioc_state_t        state_q;
  logic [CNT_W-1:0]  step_q;
  logic              is_write_q;
  logic [1:0]        dev_q;
  logic              start, cmd_load, cmd_done, rec_load, rec_busy, wd_busy;
  logic [CNT_W-1:0]  wait_val;

  // a cycle is accepted only on the latched strobe edge with io select
  assign start    = (state_q == IOC_IDLE) && latched_cycle_strobe_n_act && io_sel && !busy_s2_q;
  assign cmd_load = (state_q == IOC_SETUP) && (step_q == '0) && !rec_busy
                    && !(is_write_q && wd_busy);
  assign rec_load = (state_q == IOC_CMD) && cmd_done;
  assign wait_val = dev_wait(dev_q);

  // wait state counter: loaded at command start
  ioc_down_counter #(.W(CNT_W)) u_wait (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .load_in    (cmd_load),
    .value_in   (wait_val),
    .busy_out   (),
    .zero_out   (cmd_done)
  );

  // recovery hold counter: loaded at command end, slowest device float time
  ioc_down_counter #(.W(CNT_W)) u_recover (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .load_in    (rec_load),
    .value_in   (CNT_W'(RECOVERY_CLKS)),
    .busy_out   (rec_busy),
    .zero_out   ()
  );

  // write-data delay after a read cycle, guards against float contention
  logic [CNT_W-1:0] wd_cnt_q;
  assign wd_busy = (wd_cnt_q != '0);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_cnt_q <= '0;
    end else if (rec_load && !is_write_q) begin
      wd_cnt_q <= CNT_W'(WDATA_DELAY_CLKS);
    end else if (wd_busy) begin
      wd_cnt_q <= wd_cnt_q - 1'b1;
    end
  end

  // cycle sequencer
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q     <= IOC_IDLE;
      step_q      <= '0;
      is_write_q  <= 1'b0;
      dev_q       <= 2'h0;
    end else begin
      case (state_q)
        IOC_IDLE: begin
          if (start) begin
            state_q    <= IOC_SETUP;
            is_write_q <= wnr_s2_q;
            dev_q      <= dev_idx;
            step_q     <= CS_SETUP_CLKS - 8'h01;
          end
        end
        IOC_SETUP: begin
          if (step_q != '0) begin
            step_q <= step_q - 1'b1;
          end else if (cmd_load) begin
            state_q <= IOC_CMD;
          end
        end
        IOC_CMD: begin
          if (cmd_done) begin
            step_q      <= CNT_W'(WR_HOLD_CLKS);
            state_q     <= is_write_q ? IOC_WHOLD : IOC_READY;
          end
        end
        IOC_WHOLD: begin
          if (step_q > 8'h01) begin
            step_q <= step_q - 1'b1;
          end else begin
            state_q <= IOC_READY;
          end
        end
        IOC_READY: begin
          state_q <= IOC_IDLE;
        end
        default: state_q <= IOC_IDLE;
      endcase
    end
  end

  // chip select and address latches: captured at start; chip selects cleared after ready, address held until the next start
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dev_cs_n_out <= '1;
      io_addr_out  <= '0;
    end else if (start) begin
      dev_cs_n_out <= ~(DEV_N'(1) << dev_idx);
      io_addr_out  <= addr_s2_q;
    end else if (state_q == IOC_READY) begin
      dev_cs_n_out <= '1;
    end
  end

  // active command phase: from the load edge until the wait counter runs out
  logic cmd_phase;
  assign cmd_phase = cmd_load || (state_q == IOC_CMD && !cmd_done);

  // read command: low only in the active phase of a read
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_read_cmd_n_out <= 1'b1;
    end else begin
      io_read_cmd_n_out <= !(cmd_phase && !is_write_q);
    end
  end

  // write command: low only in the active phase of a write
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_write_cmd_n_out <= 1'b1;
    end else begin
      io_write_cmd_n_out <= !(cmd_phase && is_write_q);
    end
  end

  // ready: driven in the terminating clock, and driven high the clock before on writes; otherwise floated
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_n_out      <= 1'b1;
      ready_n_oe_n_out <= 1'b1;
    end else begin
      ready_n_out      <= !(state_q == IOC_WHOLD && step_q <= 8'h01)
                          && !(state_q == IOC_CMD && cmd_done && !is_write_q);
      ready_n_oe_n_out <= !((state_q == IOC_CMD && cmd_done) || state_q == IOC_WHOLD);
    end
  end

  // cache enable: io cycles must never fill the data cache
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cacheable_n_out <= 1'b1;
    end else begin
      cacheable_n_out <= io_sel || ads_s2_q;
    end
  end

  // address latch enable follows the latched strobe, the only edge with a valid address
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_latch_en_out <= 1'b0;
    end else begin
      addr_latch_en_out <= latched_cycle_strobe_n_act;
    end
  end

  // address buffer toward the slaves, open for the whole io cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_buf_en_n_out <= 1'b1;
    end else begin
      addr_buf_en_n_out <= (state_q == IOC_IDLE);
    end
  end

  // data buffer: a write waits while a slow slave may still be floating read data
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_buf_en_n_out <= 1'b1;
    end else begin
      data_buf_en_n_out <= (state_q == IOC_IDLE) || (state_q == IOC_SETUP && is_write_q
                           && wd_busy);
    end
  end

  // data direction follows the kind of the accepted cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_dir_write_out <= 1'b0;
    end else begin
      data_dir_write_out <= is_write_q;
    end
  end

  // recovery hold rises with the command end so no gap lets a new command in
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      recovery_hold_out <= 1'b0;
    end else begin
      recovery_hold_out <= rec_busy || rec_load;
    end
  end

  // io region select, straight from the decode
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_region_select_out <= 1'b0;
    end else begin
      io_region_select_out <= io_sel;
    end
  end

  // memory region select, the complement of the io decode
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      memory_region_select_out <= 1'b0;
    end else begin
      memory_region_select_out <= mem_sel;
    end
  end
endmodule
`default_nettype wire

//--- ioc_io_cycle_control_checker.sv
// port checker for the io cycle control block, bound to the design
`timescale 1ns/1ps
`default_nettype none
module ioc_io_cycle_control_checker
  import ioc_pkg::*;
(
  input wire logic                       clk_sys_in,
  input wire logic                       rst_n_in,
  input wire logic                       cacheable_n_out,
  input wire logic                       ready_n_out,
  input wire logic                       ready_n_oe_n_out,
  input wire logic [ioc_pkg::DEV_N-1:0]  dev_cs_n_out,
  input wire logic                       io_read_cmd_n_out,
  input wire logic                       io_write_cmd_n_out,
  input wire logic                       recovery_hold_out,
  input wire logic                       io_region_select_out,
  input wire logic                       memory_region_select_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic       cmd_idle;
  logic [7:0] run_q;
  // no command of either kind active
  assign cmd_idle = io_read_cmd_n_out & io_write_cmd_n_out;
  // length of the active command, so the width check needs no long repetition
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) run_q <= 8'h00;
    else if (cmd_idle) run_q <= 8'h00;
    else run_q <= run_q + 8'h01;
  end
  property p_region; !(io_region_select_out && memory_region_select_out); endproperty
  a_region: assert property (p_region) else $error("both region selects high");
  property p_cache; io_region_select_out |-> cacheable_n_out; endproperty
  a_cache: assert property (p_cache) else $error("io cycle marked cacheable");
  property p_excl; io_read_cmd_n_out || io_write_cmd_n_out; endproperty
  a_excl: assert property (p_excl) else $error("read and write both active");
  property p_cs1hot; !cmd_idle |-> $onehot(~dev_cs_n_out); endproperty
  a_cs1hot: assert property (p_cs1hot) else $error("no single chip select");
  property p_rdy1; !ready_n_out |=> ready_n_out; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
  property p_float; !ready_n_out |-> !ready_n_oe_n_out ##1 ready_n_oe_n_out; endproperty
  a_float: assert property (p_float) else $error("ready drive not limited");
  property p_setup;
    ($fell(io_read_cmd_n_out) || $fell(io_write_cmd_n_out)) |-> $past(dev_cs_n_out, 2) != 4'hF;
  endproperty
  a_setup: assert property (p_setup) else $error("command without chip select setup");
  property p_width; $rose(cmd_idle) |-> run_q >= 8'h14; endproperty
  a_width: assert property (p_width) else $error("command too short");
  property p_cshold; $rose(cmd_idle) |-> dev_cs_n_out != 4'hF; endproperty
  a_cshold: assert property (p_cshold) else $error("chip select dropped with command");
  property p_wrhold; !ready_n_out |-> io_write_cmd_n_out && $past(io_write_cmd_n_out); endproperty
  a_wrhold: assert property (p_wrhold) else $error("ready before write edge");
  property p_recov; recovery_hold_out |-> cmd_idle; endproperty
  a_recov: assert property (p_recov) else $error("command during recovery");
  property p_reclen; $rose(recovery_hold_out) |-> recovery_hold_out [*8]; endproperty
  a_reclen: assert property (p_reclen) else $error("recovery too short");
  property p_recload; $rose(cmd_idle) |-> ##[0:4] recovery_hold_out; endproperty
  a_recload: assert property (p_recload) else $error("recovery not loaded");
endmodule
bind ioc_io_cycle_control ioc_io_cycle_control_checker u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cacheable_n_out(cacheable_n_out),
  .ready_n_out(ready_n_out), .ready_n_oe_n_out(ready_n_oe_n_out), .dev_cs_n_out(dev_cs_n_out),
  .io_read_cmd_n_out(io_read_cmd_n_out), .io_write_cmd_n_out(io_write_cmd_n_out),
  .recovery_hold_out(recovery_hold_out), .io_region_select_out(io_region_select_out),
  .memory_region_select_out(memory_region_select_out));
`default_nettype wire

//--- ioc_cpu_model.sv
// processor bus model: issues one cycle at a time and waits for ready
`timescale 1ns/1ps
`default_nettype none
module ioc_cpu_model
  import ioc_pkg::*;
(
  input  wire logic                        clk_sys_in,
  input  wire logic                        ready_n_in,
  output var  logic [ioc_pkg::ADDR_W-1:0]  addr_out,
  output var  logic                        bus_cycle_strobe_n_out,
  output var  logic                        latched_cycle_strobe_n_out,
  output var  logic                        write_not_read_out
);
  // idle bus at time zero
  initial begin
    addr_out = '0;
    bus_cycle_strobe_n_out = 1'b1;
    latched_cycle_strobe_n_out = 1'b1;
    write_not_read_out = 1'b0;
  end
  // strobes pulse one cycle only: a held strobe would be taken twice
  task automatic cycle(input logic [ADDR_W-1:0] a, input logic wr, input int lim, output int n);
    @(posedge clk_sys_in);
    addr_out <= a;
    write_not_read_out <= wr;
    bus_cycle_strobe_n_out <= 1'b0;
    @(posedge clk_sys_in);
    bus_cycle_strobe_n_out <= 1'b1;
    latched_cycle_strobe_n_out <= 1'b0;
    @(posedge clk_sys_in);
    latched_cycle_strobe_n_out <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (ready_n_in !== 1'b0 && n < lim);
    @(posedge clk_sys_in);
    addr_out <= ~a; // address held until ready, then no longer the old value
  endtask
endmodule
`default_nettype wire

//--- ioc_io_cycle_control_test.sv
// self-checking bench for the io cycle control block
`timescale 1ns/1ps
`default_nettype none
module ioc_io_cycle_control_test;
  import ioc_pkg::*;
  logic              clk_sys_in, rst_n_in, dram_pending_in, bcs_n, lcs_n, wnr;
  logic [ADDR_W-1:0] addr, io_addr;
  logic              cacheable_n, ready_n, ready_oe_n, ale, rd_n, wr_n, mem_sel;
  logic              abuf_n, dbuf_n, ddir, recov, io_sel, mem_seen, wr_cmd;
  logic [DEV_N-1:0]  cs_n, cs_cmd;
  wire logic         ready_w;
  int                num_errors, n_compared, run, len_last, gap, gap_last, n_cmds, n_ale;
  logic [ADDR_W-1:0] io_addr_cmd;
  logic              ddir_cmd, cach_cmd;
  logic [1:0]        buf_cmd;
  assign ready_w = ready_oe_n ? 1'b1 : ready_n; // pull-up on the shared ready line
  initial clk_sys_in = 1'b0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  ioc_io_cycle_control dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .bus_cycle_strobe_n_in(bcs_n), .latched_cycle_strobe_n_in(lcs_n), .write_not_read_in(wnr),
    .dram_pending_in(dram_pending_in), .cacheable_n_out(cacheable_n), .ready_n_out(ready_n),
    .ready_n_oe_n_out(ready_oe_n), .addr_latch_en_out(ale), .io_addr_out(io_addr),
    .dev_cs_n_out(cs_n), .io_read_cmd_n_out(rd_n), .io_write_cmd_n_out(wr_n),
    .addr_buf_en_n_out(abuf_n), .data_buf_en_n_out(dbuf_n), .data_dir_write_out(ddir),
    .recovery_hold_out(recov), .io_region_select_out(io_sel),
    .memory_region_select_out(mem_sel));
  ioc_cpu_model cpu (.clk_sys_in(clk_sys_in), .ready_n_in(ready_w), .addr_out(addr),
    .bus_cycle_strobe_n_out(bcs_n), .latched_cycle_strobe_n_out(lcs_n),
    .write_not_read_out(wnr));
  // watch commands: start count, chip select, kind, length and idle gap before it
  initial {run, gap, n_cmds, n_ale, mem_seen} = '0;
  always @(posedge clk_sys_in) begin
    if (!rd_n || !wr_n) begin
      if (run == 0) begin
        gap_last <= gap;
        cs_cmd <= cs_n;
        wr_cmd <= !wr_n;
        io_addr_cmd <= io_addr;
        ddir_cmd <= ddir;
        cach_cmd <= cacheable_n;
        buf_cmd <= {abuf_n, dbuf_n};
        n_cmds <= n_cmds + 1;
      end
      run <= run + 1;
      gap <= 0;
    end else begin
      if (run != 0) len_last <= run;
      run <= 0;
      gap <= gap + 1;
    end
    if (mem_sel) mem_seen <= 1'b1;
    if (ale) n_ale <= n_ale + 1;
  end
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ge(input int got, input int lo);
    n_compared++;
    if (got < lo) begin
      num_errors++;
      $display("Error at %0t: got %h below %h", $time, got, lo);
    end
  endtask
  function automatic int need(input int d);
    case (d)
      0: return CMD_CLKS_0;
      1: return CMD_CLKS_1;
      2: return CMD_CLKS_2;
      default: return CMD_CLKS_3;
    endcase
  endfunction
  // outputs idle and ready floated while reset is held
  task automatic t_reset();
    chk({ready_n, ready_oe_n, rd_n, wr_n, cs_n}, 32'h0000_00FF);
  endtask
  // memory address: no command, no ready from this block
  task automatic t_mem();
    int n, c0;
    c0 = n_cmds;
    cpu.cycle(32'h1000_0000, 1'b0, 40, n);
    chk(n, 40);
    chk(n_cmds - c0, 0);
    chk(mem_seen, 1'b1);
  endtask
  // one io cycle to a device, judged on kind, select, width and recovery gap
  task automatic t_io(input int dev, input logic wr);
    int n, c0, a0;
    logic [ADDR_W-1:0] a;
    a = IO_BASE | (32'(dev) << DEV_SEL_LSB);
    c0 = n_cmds;
    a0 = n_ale;
    cpu.cycle(a, wr, 600, n);
    @(negedge clk_sys_in);
    if (n >= 600) begin
      num_errors++;
      end_of_test();
    end
    chk(n_cmds - c0, 1);
    chk(wr_cmd, wr);
    chk(cs_cmd, 4'(~(4'h1 << dev)));
    chk(io_addr_cmd, a);
    chk(ddir_cmd, wr);
    chk(buf_cmd, 2'b00);
    chk(cach_cmd, 1'b1);
    chk(n_ale - a0, 1);
    chk_ge(len_last, need(dev));
    chk_ge(gap_last, RECOVERY_CLKS);
  endtask
  // strobe while dram cycles are pending is not started
  task automatic t_dram();
    int n, c0;
    c0 = n_cmds;
    @(posedge clk_sys_in);
    dram_pending_in <= 1'b1;
    cpu.cycle(IO_BASE, 1'b0, 60, n);
    chk(n, 60);
    chk(n_cmds - c0, 0);
    @(posedge clk_sys_in);
    dram_pending_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    t_io(2, 1'b1);
  endtask
  // main sequence: back-to-back reads and writes to every device
  initial begin
    rst_n_in = 1'b0;
    dram_pending_in = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_sys_in);
    t_reset();
    rst_n_in <= 1'b1;
    t_mem();
    for (int d = 0; d < DEV_N; d++) begin
      t_io(d, 1'b0);
      t_io(d, 1'b1);
    end
    t_dram();
    end_of_test();
  end
endmodule
`default_nettype wire
